/* File: hw/cwbu_map.svh */
// Offsets, field positions, reset values and steps of the compare unit.
// Assumes a byte-addressed Avalon-MM slave, one 32-bit word per register.
`ifndef CWBU_MAP_SVH
`define CWBU_MAP_SVH

// ==================================================
// Register byte offsets
`define CWBU_OFF_CTRL 10'h000
`define CWBU_OFF_FLAGS 10'h004
`define CWBU_OFF_ACC 10'h008
`define CWBU_OFF_FIRST 10'h00c
`define CWBU_OFF_SOURCE 10'h010
`define CWBU_OFF_SECOND 10'h014
`define CWBU_OFF_FADDR 10'h018
`define CWBU_OFF_BOFF 10'h01c
`define CWBU_OFF_PC 10'h020
`define CWBU_OFF_STATUS 10'h024
`define CWBU_MEM_SEL 2'h1

// ==================================================
// Control and status fields
`define CWBU_CTRL_GO 0
`define CWBU_CTRL_OP_LSB 1
`define CWBU_CTRL_OP_MSB 2
`define CWBU_CTRL_SIZE 3
`define CWBU_CTRL_MODE_LSB 4
`define CWBU_CTRL_MODE_MSB 6
`define CWBU_STAT_BUSY 0
`define CWBU_STAT_TAKEN 1

// ==================================================
// Flag register bit positions
`define CWBU_FLAG_C 0
`define CWBU_FLAG_Z 1
`define CWBU_FLAG_SERR 2
`define CWBU_FLAG_N 3
`define CWBU_FLAG_HCARRY 8

// ==================================================
// Reset values and steps
`define CWBU_RST_WORD 16'h0000
`define CWBU_PC_STEP 16'h0002
`define CWBU_STEP_BYTE 16'h0001
`define CWBU_STEP_WORD 16'h0002

`endif

/* File: hw/cwbu_pkg.sv */
// Types shared by the compare-with-borrow unit.
// Assumes cwbu_map.svh holds all numeric constants.
package cwbu_pkg;

   // ==================================================
   // Operation selected by the decoder
   typedef enum logic [1:0] {
      CWBU_OP_FILE = 2'b00,
      CWBU_OP_REG = 2'b01,
      CWBU_OP_BREQ = 2'b10,
      CWBU_OP_NONE = 2'b11
   } cwbu_op_t;

   // Source addressing kind
   typedef enum logic [2:0] {
      CWBU_AM_DIRECT = 3'b000,
      CWBU_AM_IND = 3'b001,
      CWBU_AM_POSTINC = 3'b010,
      CWBU_AM_POSTDEC = 3'b011,
      CWBU_AM_PREINC = 3'b100,
      CWBU_AM_PREDEC = 3'b101,
      CWBU_AM_RSV6 = 3'b110,
      CWBU_AM_RSV7 = 3'b111
   } cwbu_mode_t;

   // Execution sequence
   typedef enum logic [2:0] {
      CWBU_ST_IDLE = 3'b000,
      CWBU_ST_FETCH = 3'b001,
      CWBU_ST_EXEC = 3'b010,
      CWBU_ST_FLUSH = 3'b011,
      CWBU_ST_NOP = 3'b100
   } cwbu_state_t;

endpackage : cwbu_pkg

/* File: hw/cwbu_alu_if.sv */
// Operand and flag bundle between the sequencer and the subtractor.
// Assumes both ends use the same data width.
`timescale 1ns/1ps
interface cwbu_alu_if #(parameter int W = 16);
   logic [W-1:0] a;
   logic [W-1:0] b;
   logic byte_mode;
   logic c_in;
   logic z_in;
   logic [W-1:0] result;
   logic c_out;
   logic z_out;
   logic n_out;
   logic sgnerr_out;
   logic hcarry_out;
   logic zero;

   modport core (output a, b, byte_mode, c_in, z_in,
                 input result, c_out, z_out, n_out, sgnerr_out, hcarry_out, zero);
   modport alu (input a, b, byte_mode, c_in, z_in,
                output result, c_out, z_out, n_out, sgnerr_out, hcarry_out, zero);
endinterface : cwbu_alu_if

/* File: hw/cwbu_borrow_alu.sv */
// Subtract-with-borrow datapath: a - b - not(c), flags for byte or word.
// Assumes an even width W; byte mode works on the low half.
`timescale 1ns/1ps
module cwbu_borrow_alu #(parameter int W = 16) (
   cwbu_alu_if.alu io
);
   localparam int H = W / 2;
   logic [W:0] sum_full;
   logic [H:0] sum_lo;
   logic [4:0] sum_nib;
   logic a_msb;
   logic b_msb;

   // ==================================================
   // Adder chains: a plus inverted b plus carry
   always_comb begin
      sum_full = {1'b0, io.a} + {1'b0, ~io.b} + {{W{1'b0}}, io.c_in};
      sum_lo = {1'b0, io.a[H-1:0]} + {1'b0, ~io.b[H-1:0]} + {{H{1'b0}}, io.c_in};
      sum_nib = {1'b0, io.a[3:0]} + {1'b0, ~io.b[3:0]} + {4'h0, io.c_in};
   end

   // Width selection and flag forming
   always_comb begin
      if (io.byte_mode) begin
         io.result = {{(W-H){1'b0}}, sum_lo[H-1:0]};
         io.c_out = sum_lo[H];
         io.hcarry_out = sum_nib[4];
         io.n_out = sum_lo[H-1];
         io.zero = (sum_lo[H-1:0] == '0);
         a_msb = io.a[H-1];
         b_msb = io.b[H-1];
      end else begin
         io.result = sum_full[W-1:0];
         io.c_out = sum_full[W];
         io.hcarry_out = sum_lo[H];
         io.n_out = sum_full[W-1];
         io.zero = (sum_full[W-1:0] == '0);
         a_msb = io.a[W-1];
         b_msb = io.b[W-1];
      end
      io.sgnerr_out = (a_msb != b_msb) && (io.n_out != a_msb);
      // Zero can only be cleared, never set
      io.z_out = io.z_in & io.zero;
   end
endmodule : cwbu_borrow_alu

/* File: hw/cwbu_data_mem.sv */
// Word-wide data memory with one byte-enabled write port and two reads.
// Assumes writes come from the bus and reads are combinational.
`timescale 1ns/1ps
module cwbu_data_mem #(
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_idx,
   input wire logic [15:0] wr_data,
   input wire logic [1:0] wr_be,
   input wire logic [AW-1:0] rd_a_idx,
   output logic [15:0] rd_a_data,
   input wire logic [AW-1:0] rd_b_idx,
   output logic [15:0] rd_b_data
);
   logic [15:0] mem [DEPTH];

   // ==================================================
   // Byte-lane write
   always_ff @(posedge clk) begin
      if (wr_en && wr_be[0]) begin
         mem[wr_idx][7:0] <= wr_data[7:0];
      end
      if (wr_en && wr_be[1]) begin
         mem[wr_idx][15:8] <= wr_data[15:8];
      end
   end

   // Read ports
   assign rd_a_data = mem[rd_a_idx];
   assign rd_b_data = mem[rd_b_idx];
endmodule : cwbu_data_mem

/* File: hw/cwbu_compare_with_borrow_unit.sv */
// Compare-with-borrow and compare-branch-if-equal execution unit.
// Assumes an Avalon-MM master with waitrequest and a 50 MHz core clock.
`timescale 1ns/1ps
`include "cwbu_map.svh"
module cwbu_compare_with_borrow_unit
   import cwbu_pkg::*;
#(
   parameter int MEM_DEPTH = 64
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [15:0] flag_bits,
   output logic [15:0] prog_counter,
   output logic busy,
   output logic discard_prefetch,
   output logic nop_slot
);
   localparam int AW = $clog2(MEM_DEPTH);

   // ==================================================
   // Helper functions
   // Byte-lane merge of a bus write into a 16-bit register
   function automatic logic [15:0] cwbu_merge(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] be);
      return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction : cwbu_merge

   // Operand pick from a memory word by byte address bit and size
   function automatic logic [15:0] cwbu_pick(input logic [15:0] w,
                                             input logic hi,
                                             input logic bsel);
      if (bsel) begin
         return {8'h00, hi ? w[15:8] : w[7:0]};
      end
      return w;
   endfunction : cwbu_pick

   // ==================================================
   // State
   cwbu_state_t state_r, state_nxt;
   cwbu_op_t op_r, op_nxt;
   cwbu_mode_t mode_r, mode_nxt;
   logic byte_r, byte_nxt;
   logic [15:0] acc_r, acc_nxt;
   logic [15:0] first_r, first_nxt;
   logic [15:0] src_r, src_nxt;
   logic [15:0] second_r, second_nxt;
   logic [15:0] faddr_r, faddr_nxt;
   logic [5:0] boff_r, boff_nxt;
   logic [15:0] pc_r, pc_nxt;
   logic [15:0] flag_r, flag_nxt;
   logic [15:0] opa_r, opa_nxt;
   logic [15:0] opb_r, opb_nxt;
   logic taken_r, taken_nxt;
   logic ack_r, ack_nxt;
   logic [15:0] rdata_r, rdata_nxt;

   logic req;
   logic wr_en;
   logic mem_sel;
   logic mem_we;
   logic [15:0] mem_a_data;
   logic [15:0] mem_b_data;
   logic [AW-1:0] mem_b_idx;
   logic [15:0] step;
   logic [15:0] ea;
   logic [15:0] target;
   logic [15:0] rd_mux;

   cwbu_alu_if #(.W(16)) alu_io ();

   cwbu_borrow_alu #(.W(16)) u_alu (
      .io(alu_io)
   );

   cwbu_data_mem #(.DEPTH(MEM_DEPTH), .AW(AW)) u_mem (
      .clk(clk),
      .wr_en(mem_we),
      .wr_idx(avs_address[AW+1:2]),
      .wr_data(avs_writedata[15:0]),
      .wr_be(avs_byteenable[1:0]),
      .rd_a_idx(avs_address[AW+1:2]),
      .rd_a_data(mem_a_data),
      .rd_b_idx(mem_b_idx),
      .rd_b_data(mem_b_data)
   );

   // ==================================================
   // Bus handshake: answer one cycle after the request, only while idle
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_r;
   assign wr_en = avs_write & ack_r;
   assign mem_sel = (avs_address[9:8] == `CWBU_MEM_SEL);
   assign mem_we = wr_en & mem_sel;
   assign avs_readdata = {16'h0000, rdata_r};

   // Outputs
   assign flag_bits = flag_r;
   assign prog_counter = pc_r;
   assign busy = (state_r != CWBU_ST_IDLE);
   assign discard_prefetch = (state_r == CWBU_ST_FLUSH);
   assign nop_slot = (state_r == CWBU_ST_NOP);

   // Subtractor hookup; branch compare is a plain subtract with no borrow
   assign alu_io.a = opa_r;
   assign alu_io.b = opb_r;
   assign alu_io.byte_mode = byte_r;
   assign alu_io.c_in = (op_r == CWBU_OP_BREQ) ? 1'b1 : flag_r[`CWBU_FLAG_C];
   assign alu_io.z_in = (op_r == CWBU_OP_BREQ) ? 1'b1 : flag_r[`CWBU_FLAG_Z];

   // ==================================================
   // Addresses: pointer step, effective address, branch target
   always_comb begin
      step = byte_r ? `CWBU_STEP_BYTE : `CWBU_STEP_WORD;
      case (mode_r)
         CWBU_AM_PREINC: ea = src_r + step;
         CWBU_AM_PREDEC: ea = src_r - step;
         default: ea = src_r;
      endcase
      mem_b_idx = (op_r == CWBU_OP_FILE) ? faddr_r[AW:1] : ea[AW:1];
      target = pc_r + `CWBU_PC_STEP + {{9{boff_r[5]}}, boff_r, 1'b0};
   end

   // Register read multiplexer
   always_comb begin
      rd_mux = 16'h0000;
      if (mem_sel) begin
         rd_mux = mem_a_data;
      end else begin
         case (avs_address)
            `CWBU_OFF_CTRL: rd_mux = {9'h000, mode_r, byte_r, op_r, 1'b0};
            `CWBU_OFF_FLAGS: rd_mux = flag_r;
            `CWBU_OFF_ACC: rd_mux = acc_r;
            `CWBU_OFF_FIRST: rd_mux = first_r;
            `CWBU_OFF_SOURCE: rd_mux = src_r;
            `CWBU_OFF_SECOND: rd_mux = second_r;
            `CWBU_OFF_FADDR: rd_mux = faddr_r;
            `CWBU_OFF_BOFF: rd_mux = {10'h000, boff_r};
            `CWBU_OFF_PC: rd_mux = pc_r;
            `CWBU_OFF_STATUS: rd_mux = {14'h0000, taken_r, busy};
            default: rd_mux = 16'h0000;
         endcase
      end
   end

   // ==================================================
   // Next-state logic: bus writes while idle, sequence otherwise
   always_comb begin
      state_nxt = state_r;
      op_nxt = op_r;
      mode_nxt = mode_r;
      byte_nxt = byte_r;
      acc_nxt = acc_r;
      first_nxt = first_r;
      src_nxt = src_r;
      second_nxt = second_r;
      faddr_nxt = faddr_r;
      boff_nxt = boff_r;
      pc_nxt = pc_r;
      flag_nxt = flag_r;
      opa_nxt = opa_r;
      opb_nxt = opb_r;
      taken_nxt = taken_r;
      ack_nxt = req & ~ack_r & (state_r == CWBU_ST_IDLE);
      rdata_nxt = ack_nxt ? rd_mux : rdata_r;
      case (state_r)
         CWBU_ST_IDLE: begin
            if (wr_en && !mem_sel) begin
               case (avs_address)
                  `CWBU_OFF_CTRL: begin
                     if (avs_byteenable[0]) begin
                        op_nxt = cwbu_op_t'(avs_writedata[`CWBU_CTRL_OP_MSB:`CWBU_CTRL_OP_LSB]);
                        byte_nxt = avs_writedata[`CWBU_CTRL_SIZE];
                        mode_nxt = cwbu_mode_t'(
                           avs_writedata[`CWBU_CTRL_MODE_MSB:`CWBU_CTRL_MODE_LSB]);
                        if (avs_writedata[`CWBU_CTRL_GO]) begin
                           state_nxt = CWBU_ST_FETCH;
                        end
                     end
                  end
                  `CWBU_OFF_FLAGS: flag_nxt = cwbu_merge(flag_r, avs_writedata, avs_byteenable);
                  `CWBU_OFF_ACC: acc_nxt = cwbu_merge(acc_r, avs_writedata, avs_byteenable);
                  `CWBU_OFF_FIRST: first_nxt = cwbu_merge(first_r, avs_writedata, avs_byteenable);
                  `CWBU_OFF_SOURCE: src_nxt = cwbu_merge(src_r, avs_writedata, avs_byteenable);
                  `CWBU_OFF_SECOND: second_nxt = cwbu_merge(second_r, avs_writedata,
                                                            avs_byteenable);
                  `CWBU_OFF_FADDR: faddr_nxt = cwbu_merge(faddr_r, avs_writedata, avs_byteenable);
                  `CWBU_OFF_BOFF: begin
                     if (avs_byteenable[0]) begin
                        boff_nxt = avs_writedata[5:0];
                     end
                  end
                  `CWBU_OFF_PC: pc_nxt = cwbu_merge(pc_r, avs_writedata, avs_byteenable);
                  default: ;
               endcase
            end
         end
         CWBU_ST_FETCH: begin
            state_nxt = CWBU_ST_EXEC;
            case (op_r)
               CWBU_OP_FILE: begin
                  // Memory word against accumulator, nothing written back
                  opa_nxt = cwbu_pick(mem_b_data, faddr_r[0], byte_r);
                  opb_nxt = cwbu_pick(acc_r, 1'b0, byte_r);
               end
               CWBU_OP_REG: begin
                  opa_nxt = cwbu_pick(first_r, 1'b0, byte_r);
                  if (mode_r == CWBU_AM_DIRECT || mode_r == CWBU_AM_RSV6 ||
                      mode_r == CWBU_AM_RSV7) begin
                     opb_nxt = cwbu_pick(src_r, 1'b0, byte_r);
                  end else begin
                     opb_nxt = cwbu_pick(mem_b_data, ea[0], byte_r);
                  end
                  if (mode_r == CWBU_AM_PREINC || mode_r == CWBU_AM_PREDEC) begin
                     src_nxt = ea;
                  end
               end
               CWBU_OP_BREQ: begin
                  opa_nxt = cwbu_pick(first_r, 1'b0, byte_r);
                  opb_nxt = cwbu_pick(second_r, 1'b0, byte_r);
               end
               default: state_nxt = CWBU_ST_IDLE;
            endcase
         end
         CWBU_ST_EXEC: begin
            if (op_r == CWBU_OP_BREQ) begin
               // Equal: jump and drop the prefetched word; flags untouched
               if (alu_io.zero) begin
                  pc_nxt = target;
                  taken_nxt = 1'b1;
                  state_nxt = CWBU_ST_FLUSH;
               end else begin
                  pc_nxt = pc_r + `CWBU_PC_STEP;
                  taken_nxt = 1'b0;
                  state_nxt = CWBU_ST_IDLE;
               end
            end else begin
               flag_nxt[`CWBU_FLAG_C] = alu_io.c_out;
               flag_nxt[`CWBU_FLAG_Z] = alu_io.z_out;
               flag_nxt[`CWBU_FLAG_SERR] = alu_io.sgnerr_out;
               flag_nxt[`CWBU_FLAG_N] = alu_io.n_out;
               flag_nxt[`CWBU_FLAG_HCARRY] = alu_io.hcarry_out;
               if (op_r == CWBU_OP_REG && mode_r == CWBU_AM_POSTINC) begin
                  src_nxt = src_r + step;
               end
               if (op_r == CWBU_OP_REG && mode_r == CWBU_AM_POSTDEC) begin
                  src_nxt = src_r - step;
               end
               pc_nxt = pc_r + `CWBU_PC_STEP;
               taken_nxt = 1'b0;
               state_nxt = CWBU_ST_IDLE;
            end
         end
         CWBU_ST_FLUSH: state_nxt = CWBU_ST_NOP;
         CWBU_ST_NOP: state_nxt = CWBU_ST_IDLE;
         default: state_nxt = CWBU_ST_IDLE;
      endcase
   end

   // ==================================================
   // Registers
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= CWBU_ST_IDLE;
         op_r <= CWBU_OP_FILE;
         mode_r <= CWBU_AM_DIRECT;
         byte_r <= 1'b0;
         acc_r <= `CWBU_RST_WORD;
         first_r <= `CWBU_RST_WORD;
         src_r <= `CWBU_RST_WORD;
         second_r <= `CWBU_RST_WORD;
         faddr_r <= `CWBU_RST_WORD;
         boff_r <= 6'h00;
         pc_r <= `CWBU_RST_WORD;
         flag_r <= `CWBU_RST_WORD;
         opa_r <= `CWBU_RST_WORD;
         opb_r <= `CWBU_RST_WORD;
         taken_r <= 1'b0;
         ack_r <= 1'b0;
         rdata_r <= `CWBU_RST_WORD;
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         mode_r <= mode_nxt;
         byte_r <= byte_nxt;
         acc_r <= acc_nxt;
         first_r <= first_nxt;
         src_r <= src_nxt;
         second_r <= second_nxt;
         faddr_r <= faddr_nxt;
         boff_r <= boff_nxt;
         pc_r <= pc_nxt;
         flag_r <= flag_nxt;
         opa_r <= opa_nxt;
         opb_r <= opb_nxt;
         taken_r <= taken_nxt;
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ==================================================
   // Checks
   file_keeps_acc_a: assert property (@(posedge clk) disable iff (reset)
      (state_r == CWBU_ST_EXEC && op_r == CWBU_OP_FILE) |=> acc_r == $past(acc_r, 2))
      else $error("accumulator changed by file compare");

   reg_no_write_a: assert property (@(posedge clk) disable iff (reset)
      (state_r == CWBU_ST_FETCH && op_r == CWBU_OP_REG && mode_r == CWBU_AM_DIRECT)
      |=> ##1 (first_r == $past(first_r, 2) && src_r == $past(src_r, 2)))
      else $error("register compare wrote an operand");

   postinc_byte_a: assert property (@(posedge clk) disable iff (reset)
      (state_r == CWBU_ST_EXEC && op_r == CWBU_OP_REG && byte_r &&
       mode_r == CWBU_AM_POSTINC) |=> src_r == $past(src_r) + 16'h0001)
      else $error("post-increment byte pointer not advanced by one");

   zero_sticky_a: assert property (@(posedge clk) disable iff (reset)
      (state_r == CWBU_ST_EXEC && op_r != CWBU_OP_BREQ && !flag_r[`CWBU_FLAG_Z])
      |=> !flag_r[`CWBU_FLAG_Z])
      else $error("zero flag set by compare");

   byte_sign_a: assert property (@(posedge clk) disable iff (reset)
      (state_r == CWBU_ST_EXEC && op_r != CWBU_OP_BREQ && byte_r)
      |=> flag_r[`CWBU_FLAG_N] == $past(alu_io.result[7]))
      else $error("byte compare sign not from bit 7");

   branch_target_a: assert property (@(posedge clk) disable iff (reset)
      (state_r == CWBU_ST_EXEC && op_r == CWBU_OP_BREQ && opa_r == opb_r)
      |=> pc_r == $past(pc_r) + 16'h0002 + {{9{boff_r[5]}}, boff_r, 1'b0})
      else $error("branch target wrong");

   branch_flags_a: assert property (@(posedge clk) disable iff (reset)
      (state_r == CWBU_ST_EXEC && op_r == CWBU_OP_BREQ) |=> $stable(flag_r))
      else $error("branch compare changed flags");

   branch_flush_a: assert property (@(posedge clk) disable iff (reset)
      (state_r == CWBU_ST_EXEC && op_r == CWBU_OP_BREQ && opa_r == opb_r)
      |=> discard_prefetch ##1 nop_slot ##1 !busy)
      else $error("taken branch did not flush and run a no-op");

endmodule : cwbu_compare_with_borrow_unit

/* File: verif/cwbu_host_model.sv */
// Avalon-MM master standing in for the decoder side of the compare unit.
// Assumes clk from the bench; the slave answers through waitrequest.
`timescale 1ns/1ps
module cwbu_host_model (
   input wire logic clk,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   output logic [9:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable
);
   int timeouts = 0;
   // Idle bus at time zero
   initial begin
      avs_address = 10'h3ff;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000a5a5;
      avs_byteenable = 4'h3;
   end
   // One transfer, held until waitrequest is seen low at a rising edge or 60 more edges pass
   task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d,
                      output logic [15:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= w;
      avs_read <= ~w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 60) begin
         @(posedge clk);
         n++;
      end
      if (avs_waitrequest !== 1'b0) timeouts++;
      q = avs_readdata[15:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      avs_address <= ~a; // Released lines do not keep the last value
      avs_writedata <= {16'hffff, ~d};
      @(posedge clk);
   endtask : acc
endmodule : cwbu_host_model

/* File: verif/testbench.sv */
// Self-checking bench for the compare-with-borrow unit.
// Assumes the host model drives the bus; flags are predicted here.
`timescale 1ns/1ps
`include "cwbu_map.svh"
module testbench;
   logic clk, reset, avs_read, avs_write, avs_waitrequest, busy, disc, nop;
   logic [9:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic [15:0] flag_bits, prog_counter;
   int mismatches = 0, cmp_count = 0, disc_n = 0, nop_n = 0, seq_bad = 0;
   logic prev_disc = 1'b0;
   cwbu_compare_with_borrow_unit i_cwbu_compare_with_borrow_unit (.clk(clk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .flag_bits(flag_bits), .prog_counter(prog_counter), .busy(busy),
      .discard_prefetch(disc), .nop_slot(nop));
   cwbu_host_model i_cwbu_host_model (.clk(clk), .avs_waitrequest(avs_waitrequest),
      .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable));
   // ==================================================
   // Clock, flush watcher and shared tasks
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (disc === 1'b1) disc_n++;
      if (nop === 1'b1) nop_n++;
      if (nop === 1'b1 && prev_disc !== 1'b1) seq_bad++; // No-op must follow the flush
      prev_disc <= disc;
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      logic [15:0] q;
      i_cwbu_host_model.acc(1'b1, a, d, q);
      if (i_cwbu_host_model.timeouts != 0) close_out;
   endtask : wr
   task automatic rd(input logic [9:0] a, output logic [15:0] q);
      i_cwbu_host_model.acc(1'b0, a, 16'h0000, q);
      if (i_cwbu_host_model.timeouts != 0) close_out;
   endtask : rd
   // Predicted flags of a - b - not(C), zero flag sticky
   function automatic logic [15:0] exp_f(input logic [15:0] a, b, f, input logic bm);
      logic [16:0] s;
      logic [8:0] h;
      logic na, nb, nr;
      s = bm ? {9'h000, a[7:0]} + {9'h000, ~b[7:0]} + f[0] : {1'b0, a} + {1'b0, ~b} + f[0];
      h = bm ? {5'h00, a[3:0]} + {5'h00, ~b[3:0]} + f[0] : {1'b0, a[7:0]} + {1'b0, ~b[7:0]} + f[0];
      na = bm ? a[7] : a[15];
      nb = bm ? b[7] : b[15];
      nr = bm ? s[7] : s[15];
      exp_f = 16'h0000;
      exp_f[0] = bm ? s[8] : s[16];
      exp_f[1] = f[1] & ((bm ? {8'h00, s[7:0]} : s[15:0]) == 16'h0000);
      exp_f[2] = (na != nb) && (nr != na);
      exp_f[3] = nr;
      exp_f[8] = bm ? h[4] : h[8];
   endfunction : exp_f
   // ==================================================
   // Scenarios
   task automatic t_reset;
      logic [15:0] q;
      chk(flag_bits, 16'h0000);
      chk(prog_counter, 16'h0000);
      rd(`CWBU_OFF_STATUS, q);
      chk(q, 16'h0000);
      wr(10'h200, 16'h1234);
      rd(10'h200, q);
      chk(q, 16'h0000);
      wr(`CWBU_OFF_CTRL, 16'h0007);
      rd(`CWBU_OFF_PC, q);
      chk(q, 16'h0000);
      chk(flag_bits, 16'h0000);
   endtask : t_reset
   task automatic t_file;
      logic [15:0] q;
      logic [15:0] m[4] = '{16'h0823, 16'h2377, 16'h2377, 16'h8000};
      logic [15:0] w[4] = '{16'h8823, 16'h2377, 16'h2377, 16'h0001};
      logic [15:0] f[4] = '{16'h0000, 16'h0001, 16'h0003, 16'h0003};
      logic bm[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
      for (int i = 0; i < 4; i++) begin
         wr(10'h114, m[i]);
         wr(`CWBU_OFF_ACC, w[i]);
         wr(`CWBU_OFF_FADDR, 16'h000a);
         wr(`CWBU_OFF_FLAGS, f[i]);
         wr(`CWBU_OFF_CTRL, {12'h000, bm[i], 2'b00, 1'b1});
         chk({15'h0000, busy}, 16'h0001);
         rd(`CWBU_OFF_FLAGS, q);
         chk(q, exp_f(m[i], w[i], f[i], bm[i]));
         chk(flag_bits, exp_f(m[i], w[i], f[i], bm[i]));
         rd(10'h114, q);
         chk(q, m[i]);
         rd(`CWBU_OFF_ACC, q);
         chk(q, w[i]);
      end
   endtask : t_file
   task automatic t_reg;
      logic [15:0] q, op, p;
      logic [15:0] mw[3] = '{16'h3a10, 16'h5c4d, 16'h4000};
      for (int k = 0; k < 3; k++) wr(10'(10'h120 + 4 * k), mw[k]);
      for (int md = 0; md < 8; md++) begin
         op = (md == 0 || md > 5) ? 16'h3000 : mw[(md == 4) ? 2 : (md == 5) ? 0 : 1];
         p = (md == 0 || md > 5) ? 16'h3000 : (md == 2 || md == 4) ? 16'h0014 :
             (md == 3 || md == 5) ? 16'h0010 : 16'h0012;
         wr(`CWBU_OFF_FIRST, 16'h4000);
         wr(`CWBU_OFF_SOURCE, (md == 0 || md > 5) ? 16'h3000 : 16'h0012);
         wr(`CWBU_OFF_FLAGS, 16'h0003);
         wr(`CWBU_OFF_CTRL, {9'h000, 3'(md), 1'b0, 2'b01, 1'b1});
         rd(`CWBU_OFF_FLAGS, q);
         chk(q, exp_f(16'h4000, op, 16'h0003, 1'b0));
         rd(`CWBU_OFF_FIRST, q);
         chk(q, 16'h4000);
         rd(`CWBU_OFF_SOURCE, q);
         chk(q, p);
      end
      wr(`CWBU_OFF_FIRST, 16'h7711);
      wr(`CWBU_OFF_SOURCE, 16'h0013);
      wr(`CWBU_OFF_FLAGS, 16'h0001);
      wr(`CWBU_OFF_CTRL, {9'h000, 3'h2, 1'b1, 2'b01, 1'b1});
      rd(`CWBU_OFF_FLAGS, q);
      chk(q, exp_f(16'h7711, 16'h005c, 16'h0001, 1'b1));
      rd(`CWBU_OFF_SOURCE, q);
      chk(q, 16'h0014);
   endtask : t_reg
   task automatic t_branch;
      logic [15:0] q;
      logic [15:0] a[3] = '{16'h1000, 16'h1000, 16'h12aa};
      logic [15:0] b[3] = '{16'h1000, 16'h1001, 16'h34aa};
      logic [5:0] o[3] = '{6'h20, 6'h1f, 6'h1f};
      logic t[3] = '{1'b1, 1'b0, 1'b1};
      int d0;
      for (int i = 0; i < 3; i++) begin
         d0 = disc_n;
         wr(`CWBU_OFF_FIRST, a[i]);
         wr(`CWBU_OFF_SECOND, b[i]);
         wr(`CWBU_OFF_BOFF, {10'h000, o[i]});
         wr(`CWBU_OFF_PC, 16'h0100);
         wr(`CWBU_OFF_FLAGS, 16'h0109);
         wr(`CWBU_OFF_CTRL, {12'h000, 1'(i == 2), 2'b10, 1'b1});
         chk({15'h0000, busy}, 16'h0001);
         rd(`CWBU_OFF_PC, q);
         chk(q, t[i] ? 16'h0102 + {{9{o[i][5]}}, o[i], 1'b0} : 16'h0102);
         rd(`CWBU_OFF_FLAGS, q);
         chk(q, 16'h0109);
         rd(`CWBU_OFF_STATUS, q);
         chk(q, {14'h0000, t[i], 1'b0});
         chk(16'(disc_n - d0), {15'h0000, t[i]});
      end
      chk(16'(nop_n), 16'(disc_n));
   endtask : t_branch
   // ==================================================
   // Verdict and main sequence
   task automatic close_out;
      mismatches += i_cwbu_host_model.timeouts + seq_bad;
      $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   initial begin
      reset = 1'b1;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset;
      t_file;
      t_reg;
      t_branch;
      close_out;
   end
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      close_out;
   end
endmodule : testbench
